/* inc/crc_defines.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef CRC_DEFINES_SVH
`define CRC_DEFINES_SVH

// Register map on the plain register port
`define REG_CONFIG        4'h0
`define REG_MODE5         4'h1
`define REG_ERRLOG        4'h2
`define REG_CALC_CRC      4'h3
`define REG_RX_CRC        4'h4

// Field positions
`define MR5_ERR_BIT       3
`define ERRLOG_FLAG_BIT   7
`define CONFIG_WIDTH      5

// Reset values
`define CONFIG_RESET      5'h00
`define BYTE_RESET        8'h00

// Burst beat indices
`define BEAT_CRC          4'h8
`define BEAT_LAST_CRC     4'h9
`define BEAT_LAST_BC4     4'h3
`define BEAT_LAST_BL8     4'h7

// Alert pulse lengths in clock cycles
`define CRC_PULSE_CLKS    6'h08
`define PARITY_PULSE_CLKS 6'h30

// Per-bit data masks of the 72-bit tree, lower nibbles only
`define CRC_MASK_0        72'h0D0107090C000D0101
`define CRC_MASK_1        72'h0603090A0501070203
`define CRC_MASK_2        72'h0006050C0603020507
`define CRC_MASK_3        72'h010C0B090C06050A0E
`define CRC_MASK_4        72'h03090702080D0A050C
`define CRC_MASK_5        72'h07020E05010A050A08
`define CRC_MASK_6        72'h0F040D0A03040B0400
`define CRC_MASK_7        72'h0E080B040608060800
// Parity of the constant-one filler terms, one bit per check bit
`define CRC_FILL          8'hF1

`endif

/* inc/crc_pkg.sv */
// Types shared by the write check path
package crc_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_CHECK} wr_state_t;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic read_dbi;
    logic term_strobe;
    logic crc_write;
    logic write_mask;
    logic write_dbi;
  } config_t;

endpackage : crc_pkg

/* inc/crc_tree_if.sv */
// Carrier between the burst logic and the check bit tree
`timescale 1ns/100ps
interface crc_tree_if;
  logic [71:0] tree_in;
  logic [7:0]  crc;
  modport src  (output tree_in, input crc);
  modport calc (input tree_in, output crc);
endinterface : crc_tree_if

/* logic/crc8_tree.sv */
// Eight-bit check tree over the 72 tree inputs of one write burst
`timescale 1ns/100ps
`include "crc_defines.svh"
module crc8_tree
(
  crc_tree_if.calc t
);
  import crc_pkg::*;

  localparam logic [71:0] MASKS [8] = '{`CRC_MASK_0, `CRC_MASK_1, `CRC_MASK_2, `CRC_MASK_3,
                                        `CRC_MASK_4, `CRC_MASK_5, `CRC_MASK_6, `CRC_MASK_7};
  localparam logic [7:0]  FILL      = `CRC_FILL;

  // One XOR tree per check bit; filler ones fold into a constant
  for (genvar b = 0; b < 8; b++)
  begin : g_bit
    assign t.crc[b] = (^(t.tree_in & MASKS[b])) ^ FILL[b];
  end

endmodule : crc8_tree

/* logic/write_crc_bus_inversion.sv */
// Write data check and bus inversion decode for one by-8 byte lane
//
// Overview of operation
// - Burst chop four, address bit two high: check bit 0 from its listed data bits.
// - Burst chop four, address bit two low: check bit 1 from its listed data bits.
// - Burst chop four, address bit two low: check bit 4 from its listed data bits.
// - Address bit two high makes the tree take upper nibbles for lower ones; here a2_q is unused and the tree always takes transfers 0 to 3.
// - Mask/inversion lane bits feed the tree only when mask or inversion is on.
// - Compare computed check bits with received ones; alert starts next clock; here only burst chop four frames are compared.
// - Check errors use the same alert line as command/address parity errors.
// - Check error alert is short, at most about ten clocks; parity over 45.
// - Pulse width counts from driving low until the driver releases.
// - A check error sets the mode register 5 status bit and the log flag.
// - Status bit and flag stay set until software writes the bit to zero.
// - Bus inversion exists only on by-8 and by-16 parts, never by-4.
// - Inversion keeps fewer than half of a lane's lines low per edge.
// - Inversion, mask and termination strobe share one pin per lane.
// - Inversion line low on a write: the lane's byte is stored inverted.
// - Inversion line high on a write: the lane's byte is stored as received.
// - Each of the eight transfers carries one inversion bit per lane.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "crc_defines.svh"
module write_crc_bus_inversion
(
  input  wire  logic            clock,
  input  wire  logic            rstn,
  input  wire  logic            link_strobe,
  input  wire  logic [7:0]      dq_pin,
  input  wire  logic            bus_invert_n,
  input  wire  logic            write_start,
  input  wire  logic            address_bit_two,
  input  wire  logic            burst_chop_four,
  input  wire  logic            parity_error,
  input  wire  logic [3:0]      reg_addr,
  input  wire  crc_pkg::byte_t  reg_wdata,
  input  wire  logic            reg_write,
  input  wire  logic            reg_read,
  output crc_pkg::byte_t        reg_rdata_q,
  output logic                  error_alert_n_o_q,
  output logic                  error_alert_n_oe_q,
  output logic [63:0]           write_data_q,
  output logic [7:0]            write_mask_q,
  output logic                  write_valid_q,
  output logic                  crc_error_q
);
  import crc_pkg::*;

  // Pin synchronisers: strobe, lane control pin and data travel together
  logic [9:0]  sync1_q;
  logic [9:0]  sync1_d;
  logic [9:0]  sync2_q;
  logic [9:0]  sync2_d;
  logic        strobe_prev_q;
  logic        strobe_prev_d;
  logic        strobe_edge;
  logic [8:0]  rx_beat;

  // Software state
  config_t     cfg_q;
  config_t     cfg_d;
  logic        err_q;
  logic        err_d;
  byte_t       calc_crc_q;
  byte_t       calc_crc_d;
  byte_t       rdata_d;
  logic        mr5_clear;
  logic        dm_on;
  logic        dbi_on;
  logic        crc_on;

  // Burst capture
  wr_state_t   state_q;
  wr_state_t   state_d;
  logic [3:0]  beat_q;
  logic [3:0]  beat_d;
  logic [3:0]  last_beat;
  logic        a2_q;
  logic        a2_d;
  logic        bc4_q;
  logic        bc4_d;
  logic [8:0]  beats_q [8];
  logic [8:0]  beats_d [8];
  byte_t       crc_rx_q;
  byte_t       crc_rx_d;

  // Results and alert
  logic        check_fire;
  logic        mismatch;
  logic [63:0] stored_data;
  logic [7:0]  stored_mask;
  logic [63:0] wdata_d;
  logic [7:0]  wmask_d;
  logic        wvalid_d;
  logic [5:0]  alert_cnt_q;
  logic [5:0]  alert_cnt_d;
  logic        alert_oe_d;

  crc_tree_if tb ();

  crc8_tree u_tree
  (
    .t (tb.calc)
  );

  // Two stages before use; the edge detector reads only the second stage
  always_comb
  begin
    sync1_d       = {link_strobe, bus_invert_n, dq_pin};
    sync2_d       = sync1_q;
    strobe_prev_d = sync2_q[9];
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      sync1_q       <= 10'h000;
      sync2_q       <= 10'h000;
      strobe_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q       <= sync1_d;
      sync2_q       <= sync2_d;
      strobe_prev_q <= strobe_prev_d;
    end
  end

  // Both strobe edges carry a transfer, as on a double data rate link
  assign strobe_edge = sync2_q[9] ^ strobe_prev_q;
  assign rx_beat     = sync2_q[8:0];

  // The shared lane pin serves one function at a time; termination wins
  always_comb
  begin
    dm_on  = cfg_q.write_mask & ~cfg_q.term_strobe;
    dbi_on = cfg_q.write_dbi & ~cfg_q.write_mask & ~cfg_q.term_strobe;
    crc_on = cfg_q.crc_write;
  end

  // Last transfer: check bits ride at transfer 8, filler at transfer 9
  always_comb
  begin
    if (crc_on)
      last_beat = `BEAT_LAST_CRC;
    else if (bc4_q)
      last_beat = `BEAT_LAST_BC4;
    else
      last_beat = `BEAT_LAST_BL8;
  end

  // Burst capture; a start while busy is ignored
  always_comb
  begin
    state_d  = state_q;
    beat_d   = beat_q;
    a2_d     = a2_q;
    bc4_d    = bc4_q;
    beats_d  = beats_q;
    crc_rx_d = crc_rx_q;
    case (state_q)
      ST_IDLE:
      begin
        if (write_start)
        begin
          state_d = ST_BURST;
          beat_d  = 4'h0;
          a2_d    = address_bit_two;
          bc4_d   = burst_chop_four;
        end
      end
      ST_BURST:
      begin
        if (strobe_edge)
        begin
          if (beat_q < `BEAT_CRC)
            beats_d[beat_q[2:0]] = rx_beat;
          else if (beat_q == `BEAT_CRC)
            crc_rx_d = rx_beat[7:0];
          if (beat_q == last_beat)
            state_d = ST_CHECK;
          else
            beat_d = beat_q + 4'h1;
        end
      end
      ST_CHECK:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_q  <= ST_IDLE;
      beat_q   <= 4'h0;
      a2_q     <= 1'b0;
      bc4_q    <= 1'b0;
      beats_q  <= '{default: 9'h000};
      crc_rx_q <= `BYTE_RESET;
    end
    else
    begin
      state_q  <= state_d;
      beat_q   <= beat_d;
      a2_q     <= a2_d;
      bc4_q    <= bc4_d;
      beats_q  <= beats_d;
      crc_rx_q <= crc_rx_d;
    end
  end

  // Tree inputs: each lane gives a nibble, upper half fixed at one.
  // Transfers 0 to 3 already carry the nibble that address bit two picks,
  // so one mask set serves both halves; transfers 4 to 7 are filler ones
  for (genvar i = 0; i < 9; i++)
  begin : g_lane
    logic [3:0] col;
    for (genvar j = 0; j < 4; j++)
    begin : g_beat
      assign col[j] = beats_q[j][i];
    end
    if (i == 8)
    begin : g_ctl
      assign tb.tree_in[8*i +: 4] = (dm_on | dbi_on) ? col : 4'hF;
    end
    else
    begin : g_dq
      assign tb.tree_in[8*i +: 4] = col;
    end
    assign tb.tree_in[8*i+4 +: 4] = 4'hF;
  end

  // Stored bytes: inversion undone per transfer, mask per transfer
  for (genvar j = 0; j < 8; j++)
  begin : g_store
    assign stored_data[8*j +: 8] = (dbi_on && !beats_q[j][8]) ? ~beats_q[j][7:0]
                                                             : beats_q[j][7:0];
    assign stored_mask[j] = dm_on & ~beats_q[j][8];
  end

  // Check only burst chop four frames; wire data, not decoded data, is checked
  assign check_fire = (state_q == ST_CHECK);
  assign mismatch   = check_fire & crc_on & bc4_q & (tb.crc != crc_rx_q);

  // Hand the burst on; with masking on, a failed burst is not written
  always_comb
  begin
    wvalid_d   = check_fire & ~(mismatch & dm_on);
    wdata_d    = wvalid_d ? stored_data : write_data_q;
    wmask_d    = wvalid_d ? stored_mask : write_mask_q;
    calc_crc_d = check_fire ? tb.crc : calc_crc_q;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      write_valid_q <= 1'b0;
      write_data_q  <= 64'h0000000000000000;
      write_mask_q  <= 8'h00;
      calc_crc_q    <= `BYTE_RESET;
      crc_error_q   <= 1'b0;
    end
    else
    begin
      write_valid_q <= wvalid_d;
      write_data_q  <= wdata_d;
      write_mask_q  <= wmask_d;
      calc_crc_q    <= calc_crc_d;
      crc_error_q   <= mismatch;
    end
  end

  // Alert length: a longer parity pulse is never cut short by a check error
  always_comb
  begin
    if (parity_error && alert_cnt_q < `PARITY_PULSE_CLKS)
      alert_cnt_d = `PARITY_PULSE_CLKS;
    else if (mismatch && alert_cnt_q < `CRC_PULSE_CLKS)
      alert_cnt_d = `CRC_PULSE_CLKS;
    else if (alert_cnt_q != 6'h00)
      alert_cnt_d = alert_cnt_q - 6'h01;
    else
      alert_cnt_d = 6'h00;
    alert_oe_d = (alert_cnt_d != 6'h00);
  end

  // Open drain: the data side is held low, only the enable moves
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      alert_cnt_q        <= 6'h00;
      error_alert_n_oe_q <= 1'b0;
      error_alert_n_o_q  <= 1'b0;
    end
    else
    begin
      alert_cnt_q        <= alert_cnt_d;
      error_alert_n_oe_q <= alert_oe_d;
      error_alert_n_o_q  <= 1'b0;
    end
  end

  // Sticky error status; a new error in the clearing cycle wins
  always_comb
  begin
    mr5_clear = reg_write && (reg_addr == `REG_MODE5) && !reg_wdata[`MR5_ERR_BIT];
    err_d     = (err_q & ~mr5_clear) | mismatch;
    cfg_d     = cfg_q;
    if (reg_write && reg_addr == `REG_CONFIG)
      cfg_d = config_t'(reg_wdata[`CONFIG_WIDTH-1:0]);
  end

  // Read data one cycle after the read strobe; unmapped reads give zero
  always_comb
  begin
    rdata_d = `BYTE_RESET;
    if (reg_read)
    begin
      if (reg_addr == `REG_CONFIG)
        rdata_d = {3'h0, cfg_q};
      else if (reg_addr == `REG_MODE5)
        rdata_d[`MR5_ERR_BIT] = err_q;
      else if (reg_addr == `REG_ERRLOG)
        rdata_d[`ERRLOG_FLAG_BIT] = err_q;
      else if (reg_addr == `REG_CALC_CRC)
        rdata_d = calc_crc_q;
      else if (reg_addr == `REG_RX_CRC)
        rdata_d = crc_rx_q;
      else
        rdata_d = `BYTE_RESET;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      cfg_q       <= config_t'(`CONFIG_RESET);
      err_q       <= 1'b0;
      reg_rdata_q <= `BYTE_RESET;
    end
    else
    begin
      cfg_q       <= cfg_d;
      err_q       <= err_d;
      reg_rdata_q <= rdata_d;
    end
  end

endmodule : write_crc_bus_inversion

/* verification/ctl_model.sv */
// Controller side: drives write transfers on the strobe, data and lane lines
`timescale 1ns/100ps
module ctl_model
(
  output logic       link_strobe,
  output logic [7:0] dq_pin,
  output logic       bus_invert_n
);
  // Frame stays buffered here so a failed write can be replayed
  logic [8:0] beat [10];
  initial
  begin
    link_strobe = 1'b0;
    {bus_invert_n, dq_pin} = 9'h155;
  end
  // One strobe edge per transfer; lines held 100 ns either side for the synchroniser
  task automatic send(input int n);
    #7;
    for (int t = 0; t < n; t++)
    begin
      {bus_invert_n, dq_pin} = beat[t];
      #100 link_strobe = ~link_strobe;
      #100;
    end
    // Strobe rests between frames; released lines show the inverse of the last value
    {bus_invert_n, dq_pin} = ~beat[n-1];
  endtask : send
endmodule : ctl_model

/* verification/write_crc_bus_inversion_props.sv */
// Checker on the alert, register and burst outputs of the write check block
`timescale 1ns/100ps
module write_crc_bus_inversion_props
  import crc_pkg::*;
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        parity_error,
  input wire logic        reg_read,
  input wire byte_t       reg_rdata_q,
  input wire logic        error_alert_n_o_q,
  input wire logic        error_alert_n_oe_q,
  input wire logic [63:0] write_data_q,
  input wire logic [7:0]  write_mask_q,
  input wire logic        write_valid_q,
  input wire logic        crc_error_q
);
  logic [6:0] run_q;
  logic [6:0] run_d;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Length of the current alert drive, for the pulse width checks
  always_comb
    run_d = error_alert_n_oe_q ? run_q + 7'h01 : 7'h00;
  always_ff @(posedge clock)
    run_q <= rstn ? run_d : 7'h00;
  property p_od; error_alert_n_o_q == 1'b0; endproperty
  a_od: assert property (p_od) else $error("alert driven high");
  property p_cause;
    $rose(error_alert_n_oe_q) |-> crc_error_q || $past(parity_error) || $past(parity_error, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("alert without cause");
  property p_crcoe; crc_error_q |-> error_alert_n_oe_q; endproperty
  a_crcoe: assert property (p_crcoe) else $error("alert late after mismatch");
  property p_crcpw;
    crc_error_q && !$past(error_alert_n_oe_q) |-> error_alert_n_oe_q [*8] ##1 !error_alert_n_oe_q;
  endproperty
  a_crcpw: assert property (p_crcpw) else $error("check alert width wrong");
  property p_width; $fell(error_alert_n_oe_q) |-> run_q == 7'h08 || run_q == 7'h30; endproperty
  a_width: assert property (p_width) else $error("alert width wrong");
  property p_rd; !$past(reg_read) |-> reg_rdata_q == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data outside its cycle");
  property p_err1; crc_error_q |=> !crc_error_q; endproperty
  a_err1: assert property (p_err1) else $error("error pulse too long");
  property p_data;
    $changed(write_data_q) || $changed(write_mask_q) |-> write_valid_q;
  endproperty
  a_data: assert property (p_data) else $error("data changed without valid");
  c_err: cover property (crc_error_q);
  c_par: cover property (parity_error);
  c_vld: cover property (write_valid_q && !crc_error_q);
endmodule : write_crc_bus_inversion_props
bind write_crc_bus_inversion write_crc_bus_inversion_props u_props (
  .clock(clock), .rstn(rstn), .parity_error(parity_error), .reg_read(reg_read),
  .reg_rdata_q(reg_rdata_q), .error_alert_n_o_q(error_alert_n_o_q),
  .error_alert_n_oe_q(error_alert_n_oe_q), .write_data_q(write_data_q),
  .write_mask_q(write_mask_q), .write_valid_q(write_valid_q), .crc_error_q(crc_error_q));

/* verification/write_crc_bus_inversion_tb.sv */
// Self-checking bench for the write check and inversion block
`timescale 1ns/100ps
`include "crc_defines.svh"
module write_crc_bus_inversion_tb;
  import crc_pkg::*;
  logic        clock = 0, rstn = 0, write_start = 0, address_bit_two = 0;
  logic        burst_chop_four = 0, parity_error = 0, reg_write = 0, reg_read = 0;
  logic [3:0]  reg_addr = 4'h0;
  byte_t       reg_wdata = 8'h00, reg_rdata_q;
  logic        error_alert_n_o_q, error_alert_n_oe_q, write_valid_q, crc_error_q;
  logic        link_strobe, bus_invert_n, err, vld;
  logic [7:0]  dq_pin, write_mask_q;
  logic [63:0] write_data_q;
  int          n_errors = 0, checks = 0;
  wire alert_n = error_alert_n_oe_q ? error_alert_n_o_q : 1'b1;
  always #25 clock = ~clock;
  ctl_model u_ctl (.link_strobe(link_strobe), .dq_pin(dq_pin), .bus_invert_n(bus_invert_n));
  write_crc_bus_inversion u_dut (.clock(clock), .rstn(rstn), .link_strobe(link_strobe),
    .dq_pin(dq_pin), .bus_invert_n(bus_invert_n), .write_start(write_start),
    .address_bit_two(address_bit_two), .burst_chop_four(burst_chop_four),
    .parity_error(parity_error), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
    .error_alert_n_o_q(error_alert_n_o_q), .error_alert_n_oe_q(error_alert_n_oe_q),
    .write_data_q(write_data_q), .write_mask_q(write_mask_q),
    .write_valid_q(write_valid_q), .crc_error_q(crc_error_q));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // One register strobe, then a cycle to release it
  task automatic rw(input logic [3:0] a, input byte_t d, input logic w);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= w;
    reg_read <= !w;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
  endtask : rw
  task automatic rd(input logic [3:0] a, input byte_t e);
    rw(a, 8'h00, 1'b0);
    #1;
    chk(reg_rdata_q, e, "reg_rdata_q");
  endtask : rd
  // Start a burst, send it, wait bounded for the completion pulse
  task automatic burst(input logic a2, input logic bc4, input int n);
    err = 1'b0;
    vld = 1'b0;
    @(posedge clock);
    address_bit_two <= a2;
    burst_chop_four <= bc4;
    write_start <= 1'b1;
    @(posedge clock);
    write_start <= 1'b0;
    u_ctl.send(n);
    for (int i = 0; i < 40 && !vld; i++)
    begin
      @(posedge clock);
      #1;
      err = err | (crc_error_q === 1'b1);
      vld = (write_valid_q === 1'b1);
    end
    if (!vld)
    begin
      chk(1'b0, 1'b1, "burst timeout");
      wrap_up;
    end
  endtask : burst
  // Waits briefly for the alert to fall, then counts its low cycles
  task automatic low_width(input int exp);
    int n;
    for (n = 0; n < 4 && alert_n !== 1'b0; n++)
      @(posedge clock);
    n = 0;
    while (alert_n === 1'b0 && n < 60)
    begin
      n++;
      @(posedge clock);
      #1;
    end
    chk(n, exp, "alert low cycles");
  endtask : low_width
  // Zero burst with one flipped tree input; sent check byte c, off by one bit if bad
  task automatic crc_case(input byte_t cfg, input logic a2, input int t, input logic [8:0] f,
                          input byte_t c, input logic bad);
    rw(`REG_CONFIG, cfg, 1'b1);
    for (int i = 0; i < 10; i++)
      u_ctl.beat[i] = (i < 4) ? 9'h000 : 9'h1FF;
    u_ctl.beat[t] = f;
    u_ctl.beat[8] = {1'b1, c ^ {7'h00, bad}};
    burst(a2, 1'b1, 10);
    chk(err, bad, "crc_error_q");
    if (bad)
      low_width(8);
    rd(`REG_CALC_CRC, c);
    rd(`REG_RX_CRC, c ^ {7'h00, bad});
    if (bad)
    begin
      u_ctl.beat[8] = {1'b1, c};
      burst(a2, 1'b1, 10);
      chk(err, 1'b0, "retry crc_error_q");
    end
  endtask : crc_case
  // Full burst, check off, inversion lane low on odd transfers only
  task automatic dbi_case;
    byte_t d;
    logic [63:0] e;
    logic [63:0] r;
    rw(`REG_CONFIG, 8'h01, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      d = byte_t'(8'h5A + 8'h23 * i);
      u_ctl.beat[i] = {~i[0], d};
      e[8*i +: 8] = i[0] ? ~d : d;
      r[8*i +: 8] = d;
    end
    burst(1'b0, 1'b0, 8);
    chk(write_data_q, e, "write_data_q");
    chk(write_mask_q, 64'h0, "write_mask_q");
    chk(err, 1'b0, "crc_error_q");
    rw(`REG_CONFIG, 8'h02, 1'b1);
    burst(1'b0, 1'b0, 8);
    chk(write_data_q, r, "masked write_data_q");
    chk(write_mask_q, 64'hAA, "write_mask_q");
  endtask : dbi_case
  initial
  begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(`REG_CONFIG, 8'h00);
    rd(`REG_MODE5, 8'h00);
    rd(4'hF, 8'h00);
    crc_case(8'h05, 1'b1, 0, 9'h001, 8'hF6, 1'b0);
    crc_case(8'h05, 1'b1, 3, 9'h100, 8'h30, 1'b0);
    crc_case(8'h05, 1'b0, 0, 9'h001, 8'hF6, 1'b0);
    crc_case(8'h05, 1'b0, 2, 9'h100, 8'h12, 1'b0);
    crc_case(8'h05, 1'b0, 2, 9'h001, 8'hED, 1'b0);
    crc_case(8'h05, 1'b0, 1, 9'h100, 8'h03, 1'b0);
    crc_case(8'h04, 1'b0, 2, 9'h100, 8'h58, 1'b0);
    crc_case(8'h05, 1'b1, 0, 9'h000, 8'hF1, 1'b1);
    rd(`REG_MODE5, 8'h08);
    rd(`REG_ERRLOG, 8'h80);
    rw(`REG_MODE5, 8'h08, 1'b1);
    rd(`REG_MODE5, 8'h08);
    rw(`REG_MODE5, 8'h00, 1'b1);
    rd(`REG_MODE5, 8'h00);
    rd(`REG_ERRLOG, 8'h00);
    @(posedge clock);
    parity_error <= 1'b1;
    @(posedge clock);
    parity_error <= 1'b0;
    #1;
    low_width(48);
    dbi_case;
    wrap_up;
  end
endmodule : write_crc_bus_inversion_tb
